/* verilog/sfb_top.sv */
// Contract
// R01 - Probe flash signature at high address first
// R02 - Valid signature: enable external, fetch address zero
// R03 - No signature: stay on internal ROM
// R04 - In reset strap pin floats, pull-down on
// R05 - Release latches strap, drops pull-down, resumes
// R06 - Control register shows latched speed flag
// R07 - Single-bit and two-bit reads supported
// R08 - Works with mode 0 and mode 3; the code only idles the clock low and samples on the falling edge
// R09 - System holds reset at least 1 us
// R10 - Strap 0 slow clock, 1 fast clock
// R11 - Suspend: strap 1 float, 0 drive low
// R12 - Chip select low per access, high between
`timescale 1ns/1ps
module sfb_top
  import sfb_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic LINK_CLK_I,
  input wire logic SUSPEND_I,
  input wire logic [15:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  output logic SERIAL_CS_N_O,
  output logic SERIAL_CLK_O,
  output logic SERIAL_OUT_O,
  output logic SERIAL_OUT_OE_O,
  input wire logic SERIAL_OUT_I,
  output logic BOOT_SPEED_STRAP_PD_O,
  input wire logic SERIAL_IN_PIN_I,
  output logic EXT_ROM_EN_O,
  output logic BOOT_DONE_O,
  output logic [31:0] FETCH_WORD_O
);
  sfb_boot_e st_q;
  sfb_link_e lst_q;
  logic sp1, sp2, strap_q, latched_q;
  logic dual_q, ext_q, done_q, resp_q;
  logic [31:0] fetch_q, rdata_q;
  logic req_tg_q, cmd_dual_q, cmd_fast_q;
  logic [23:0] cmd_addr_q;
  logic a1, a2, a3, ack_ev;
  // Link domain
  logic lr1, lr2, rq1, rq2, rq3, ss1, ss2, ls1, ls2;
  logic di1, di2, do1, do2;
  logic ack_tg_q, cs_q, sck_q, oe_q, do_q, fast_q, ldual_q;
  logic [1:0] div_q;
  logic [6:0] cnt_q;
  logic [39:0] tx_q;
  logic [31:0] rx_q;
  logic [1:0] lim;
  logic [6:0] out_len, end_len;

  function automatic logic [7:0] ctl_word();
    logic [7:0] w;
    w = 8'h00;
    w[CTL_DUAL_BIT] = dual_q;
    w[CTL_SPEED_BIT] = strap_q;
    w[CTL_EXT_BIT] = ext_q;
    w[CTL_DONE_BIT] = done_q;
    return w;
  endfunction : ctl_word

  function automatic logic [31:0] reg_rd(input logic [15:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == CTL_ADDR) begin
      v = {24'h00_0000, ctl_word()};
    end else if (a == FETCH_ADDR) begin
      v = fetch_q;
    end
    return v;
  endfunction : reg_rd

  // Strap synchroniser
  always_ff @(posedge MCLK_I) begin
    sp1 <= SERIAL_OUT_I;
    sp2 <= sp1;
  end

  // R05 latch at release
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      strap_q <= CTL_SPEED_RST;
      latched_q <= 1'b0;
    end else if (!latched_q) begin
      strap_q <= sp2;
      latched_q <= 1'b1;
    end
  end

  // R04 pull-down during reset
  assign BOOT_SPEED_STRAP_PD_O = !latched_q;

  // Avalon slave
  assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !resp_q;
  assign AVS_READDATA_O = rdata_q;

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      resp_q <= 1'b0;
    end else begin
      resp_q <= (AVS_READ_I || AVS_WRITE_I) && !resp_q;
    end
  end

  // R06 control register read
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      rdata_q <= 32'h0000_0000;
    end else if (AVS_READ_I && !resp_q) begin
      rdata_q <= reg_rd(AVS_ADDRESS_I);
    end
  end

  // R07 width select write
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      dual_q <= CTL_DUAL_RST;
    end else if (AVS_WRITE_I && resp_q && AVS_ADDRESS_I == CTL_ADDR && AVS_BYTEENABLE_I[0]) begin
      dual_q <= AVS_WRITEDATA_I[CTL_DUAL_BIT];
    end
  end

  // Ack synchroniser
  always_ff @(posedge MCLK_I) begin
    a1 <= ack_tg_q;
    a2 <= a1;
    a3 <= a2;
  end
  assign ack_ev = a2 ^ a3;

  // Boot sequencer
  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      st_q <= B_LATCH;
      req_tg_q <= 1'b0;
      cmd_addr_q <= SIG_ADDR;
      cmd_dual_q <= 1'b0;
      cmd_fast_q <= 1'b0;
      ext_q <= 1'b0;
      done_q <= 1'b0;
      fetch_q <= 32'h0000_0000;
    end else begin
      case (st_q)
        B_LATCH: begin
          if (latched_q) begin
            st_q <= B_SIG_REQ;
          end
        end
        // R01 signature probe
        B_SIG_REQ: begin
          cmd_addr_q <= SIG_ADDR;
          cmd_dual_q <= dual_q;
          cmd_fast_q <= strap_q;
          req_tg_q <= !req_tg_q;
          st_q <= B_SIG_WAIT;
        end
        B_SIG_WAIT: begin
          if (ack_ev) begin
            // R03 fall back inside
            st_q <= (rx_q == SIG_WORD) ? B_FETCH_REQ : B_INT;
          end
        end
        // R02 fetch from zero
        B_FETCH_REQ: begin
          ext_q <= 1'b1;
          cmd_addr_q <= EXEC_ADDR;
          cmd_dual_q <= dual_q;
          req_tg_q <= !req_tg_q;
          st_q <= B_FETCH_WAIT;
        end
        B_FETCH_WAIT: begin
          if (ack_ev) begin
            fetch_q <= rx_q;
            done_q <= 1'b1;
            st_q <= B_EXT;
          end
        end
        B_INT: begin
          done_q <= 1'b1;
        end
        default: begin
          done_q <= 1'b1;
        end
      endcase
    end
  end

  assign EXT_ROM_EN_O = ext_q;
  assign BOOT_DONE_O = done_q;
  assign FETCH_WORD_O = fetch_q;

  // Link domain synchronisers
  always_ff @(posedge LINK_CLK_I) begin
    lr1 <= RST_I;
    lr2 <= lr1;
    rq1 <= req_tg_q;
    rq2 <= rq1;
    ss1 <= SUSPEND_I;
    ss2 <= ss1;
    ls1 <= strap_q;
    ls2 <= ls1;
    di1 <= SERIAL_IN_PIN_I;
    di2 <= di1;
    do1 <= SERIAL_OUT_I;
    do2 <= do1;
  end

  // R10 clock rate from strap
  assign lim = fast_q ? DIV_FAST : DIV_SLOW;
  assign out_len = ldual_q ? OUT_DUAL : OUT_SINGLE;
  assign end_len = ldual_q ? END_DUAL : END_SINGLE;

  // Serial engine
  always_ff @(posedge LINK_CLK_I) begin
    rq3 <= rq2;
    if (lr2) begin
      lst_q <= L_IDLE;
      cs_q <= 1'b1;
      sck_q <= 1'b0;
      oe_q <= 1'b0;
      do_q <= 1'b0;
      div_q <= 2'h0;
      cnt_q <= 7'h00;
      tx_q <= 40'h00_0000_0000;
      rx_q <= 32'h0000_0000;
      ack_tg_q <= 1'b0;
      fast_q <= 1'b0;
      ldual_q <= 1'b0;
    end else begin
      case (lst_q)
        // R12 select low per access
        L_IDLE: begin
          if (rq2 ^ rq3) begin
            lst_q <= L_SHIFT;
            cs_q <= 1'b0;
            oe_q <= 1'b1;
            tx_q <= {cmd_dual_q ? CMD_DUAL : CMD_READ, cmd_addr_q, DUMMY_BYTE};
            do_q <= cmd_dual_q ? CMD_DUAL[7] : CMD_READ[7];
            div_q <= 2'h0;
            cnt_q <= 7'h00;
            fast_q <= cmd_fast_q;
            ldual_q <= cmd_dual_q;
          end
        end
        // R08 idle low, sample fall
        L_SHIFT: begin
          if (div_q == lim) begin
            div_q <= 2'h0;
            if (!sck_q) begin
              sck_q <= 1'b1;
              cnt_q <= cnt_q + 7'h01;
            end else begin
              sck_q <= 1'b0;
              // R07 one or two bits
              if (cnt_q > out_len) begin
                rx_q <= ldual_q ? {rx_q[29:0], di2, do2} : {rx_q[30:0], di2};
              end
              if (cnt_q == end_len) begin
                cs_q <= 1'b1;
                oe_q <= 1'b0;
                lst_q <= L_END;
              end else begin
                tx_q <= {tx_q[38:0], 1'b0};
                do_q <= tx_q[38];
                oe_q <= cnt_q < out_len;
              end
            end
          end else begin
            div_q <= div_q + 2'h1;
          end
        end
        default: begin
          ack_tg_q <= !ack_tg_q;
          lst_q <= L_IDLE;
        end
      endcase
    end
  end

  assign SERIAL_CS_N_O = cs_q;
  assign SERIAL_CLK_O = sck_q;
  // R11 suspend pin state
  assign SERIAL_OUT_O = ss2 ? 1'b0 : do_q;
  assign SERIAL_OUT_OE_O = !lr2 && (ss2 ? !ls2 : oe_q);

  property p_r01;
    @(posedge MCLK_I) disable iff (RST_I)
    (st_q == B_SIG_WAIT && ack_ev && rx_q == SIG_WORD) |=> st_q == B_FETCH_REQ ##1 ext_q;
  endproperty
  a_r01: assert property (p_r01) else $error("signature not accepted"); // R01

  property p_r02;
    @(posedge MCLK_I) disable iff (RST_I)
    (st_q == B_FETCH_WAIT) |-> cmd_addr_q == EXEC_ADDR && EXT_ROM_EN_O && !BOOT_DONE_O;
  endproperty
  a_r02: assert property (p_r02) else $error("fetch not from zero"); // R02

  property p_r03;
    @(posedge MCLK_I) disable iff (RST_I)
    (st_q == B_SIG_WAIT && ack_ev && rx_q != SIG_WORD) |=> (!EXT_ROM_EN_O)[*3] ##0 BOOT_DONE_O;
  endproperty
  a_r03: assert property (p_r03) else $error("external used without signature"); // R03

  property p_r04;
    @(posedge LINK_CLK_I) lr2 |-> !SERIAL_OUT_OE_O;
  endproperty
  a_r04: assert property (p_r04) else $error("strap pin driven in reset"); // R04

  property p_r05;
    @(posedge MCLK_I) disable iff (RST_I)
    !latched_q |=> latched_q && strap_q == $past(sp2) && !BOOT_SPEED_STRAP_PD_O;
  endproperty
  a_r05: assert property (p_r05) else $error("strap not latched"); // R05

  property p_r06;
    @(posedge MCLK_I) disable iff (RST_I)
    (AVS_READ_I && AVS_ADDRESS_I == CTL_ADDR && !AVS_WAITREQUEST_O) |-> AVS_READDATA_O[CTL_SPEED_BIT] == strap_q;
  endproperty
  a_r06: assert property (p_r06) else $error("speed flag wrong"); // R06

  property p_r07;
    @(posedge LINK_CLK_I) disable iff (lr2)
    (lst_q == L_SHIFT && cnt_q > out_len) |-> !oe_q;
  endproperty
  a_r07: assert property (p_r07) else $error("data pin driven in data phase"); // R07

  property p_r08;
    @(posedge LINK_CLK_I) disable iff (lr2)
    cs_q |-> !sck_q;
  endproperty
  a_r08: assert property (p_r08) else $error("clock not idle low"); // R08

  property p_r10;
    @(posedge LINK_CLK_I) disable iff (lr2)
    ($rose(sck_q) && !fast_q) |-> sck_q[*4] ##1 !sck_q;
  endproperty
  a_r10: assert property (p_r10) else $error("slow clock period wrong"); // R10

  property p_r11;
    @(posedge LINK_CLK_I) disable iff (lr2)
    (ss2 && !ls2) |-> SERIAL_OUT_OE_O && !SERIAL_OUT_O;
  endproperty
  a_r11: assert property (p_r11) else $error("suspend pin not low"); // R11

  property p_r12;
    @(posedge LINK_CLK_I) disable iff (lr2)
    (lst_q == L_END) |-> cs_q ##1 (lst_q == L_IDLE && cs_q);
  endproperty
  a_r12: assert property (p_r12) else $error("select not high between"); // R12
endmodule : sfb_top

/* common/sfb_pkg.sv */
package sfb_pkg;
  // Register map
  localparam logic [15:0] CTL_ADDR = 16'h2400;
  localparam logic [15:0] FETCH_ADDR = 16'h2404;
  localparam logic [7:0] CTL_RESET = 8'h02;
  localparam int CTL_DUAL_BIT = 0;
  localparam int CTL_SPEED_BIT = 1;
  localparam int CTL_EXT_BIT = 2;
  localparam int CTL_DONE_BIT = 3;
  localparam logic CTL_SPEED_RST = CTL_RESET[CTL_SPEED_BIT];
  localparam logic CTL_DUAL_RST = CTL_RESET[CTL_DUAL_BIT];
  // Boot probe
  localparam logic [23:0] SIG_ADDR = 24'h00fffa;
  localparam logic [23:0] EXEC_ADDR = 24'h000000;
  localparam logic [31:0] SIG_WORD = 32'h32444655;
  // Flash commands
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_DUAL = 8'h3b;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;
  // Serial clock counts: out phase end and total rises
  localparam logic [6:0] OUT_SINGLE = 7'h20;
  localparam logic [6:0] OUT_DUAL = 7'h28;
  localparam logic [6:0] END_SINGLE = 7'h40;
  localparam logic [6:0] END_DUAL = 7'h38;
  // Link clock divider limits, half period = limit + 1
  localparam logic [1:0] DIV_FAST = 2'h1;
  localparam logic [1:0] DIV_SLOW = 2'h3;
  // Reset pulse
  localparam int CLK_NS = 25;
  localparam int RST_MIN_NS = 1000;
  localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {
    B_LATCH, B_SIG_REQ, B_SIG_WAIT, B_FETCH_REQ, B_FETCH_WAIT, B_INT, B_EXT
  } sfb_boot_e;
  typedef enum logic [1:0] {L_IDLE, L_SHIFT, L_END} sfb_link_e;
endpackage : sfb_pkg

/* testbench/sfb_flash_model.sv */
`timescale 1ns/1ps
module sfb_flash_model
  import sfb_pkg::*;
(
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic io0_i,
  input wire logic sig_ok_i,
  output logic io1_o,
  output logic io0_o,
  output logic io0_oe_o
);
  logic [31:0] sh;
  logic [31:0] word;
  logic [23:0] addr_q[$];
  int cnt;
  function automatic logic [7:0] byte_at(input logic [23:0] a);
    logic [31:0] s;
    s = 32'h32444655;
    if (sig_ok_i && a >= 24'h00fffa && a <= 24'h00fffd) return s[8 * (24'h00fffd - a) +: 8];
    return a[7:0] ^ 8'ha5;
  endfunction : byte_at
  initial begin
    cnt = 0;
    sh = 32'h0;
    io1_o = 1'b0;
    io0_o = 1'b0;
    io0_oe_o = 1'b0;
  end
  always @(negedge cs_n_i) cnt = 0;
  // Released lines fall to pull-down
  always @(posedge cs_n_i) begin
    io1_o <= 1'b0;
    io0_oe_o <= 1'b0;
  end
  always @(posedge sck_i) begin
    if (!cs_n_i) begin
      if (cnt < 32) sh = {sh[30:0], io0_i};
      cnt = cnt + 1;
      if (cnt == 32) begin
        addr_q.push_back(sh[23:0]);
        word = {byte_at(sh[23:0]), byte_at(sh[23:0] + 24'h1), byte_at(sh[23:0] + 24'h2),
                byte_at(sh[23:0] + 24'h3)};
      end
    end
  end
  always @(negedge sck_i) begin
    if (!cs_n_i && sh[31:24] == CMD_READ && cnt >= 32 && cnt < 64) io1_o <= word[63 - cnt];
    if (!cs_n_i && sh[31:24] == CMD_DUAL && cnt >= 40 && cnt < 56) begin
      io1_o <= word[111 - 2 * cnt];
      io0_o <= word[110 - 2 * cnt];
      io0_oe_o <= 1'b1;
    end
  end
endmodule : sfb_flash_model

/* testbench/sfb_top_tb.sv */
`timescale 1ns/1ps
module sfb_top_tb
  import sfb_pkg::*;
;
  logic MCLK_I, RST_I, LINK_CLK_I, SUSPEND_I, AVS_READ_I, AVS_WRITE_I;
  logic [15:0] AVS_ADDRESS_I;
  logic [31:0] AVS_WRITEDATA_I, AVS_READDATA_O, FETCH_WORD_O;
  logic [3:0] AVS_BYTEENABLE_I;
  logic AVS_WAITREQUEST_O, SERIAL_CS_N_O, SERIAL_CLK_O, SERIAL_OUT_O, SERIAL_OUT_OE_O;
  logic BOOT_SPEED_STRAP_PD_O, EXT_ROM_EN_O, BOOT_DONE_O, so, fl_io0, fl_oe, pin, strap_q, sig_q;
  int failures, check_count, hi_ns;
  realtime rise_t;
  // Pin level: device, flash, else board strap
  assign pin = SERIAL_OUT_OE_O ? SERIAL_OUT_O : (fl_oe ? fl_io0 : strap_q);
  sfb_top u_sfb_top (.MCLK_I(MCLK_I), .RST_I(RST_I), .LINK_CLK_I(LINK_CLK_I), .SUSPEND_I(SUSPEND_I),
    .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
    .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .SERIAL_CS_N_O(SERIAL_CS_N_O), .SERIAL_CLK_O(SERIAL_CLK_O), .SERIAL_OUT_O(SERIAL_OUT_O),
    .SERIAL_OUT_OE_O(SERIAL_OUT_OE_O), .SERIAL_OUT_I(pin), .BOOT_SPEED_STRAP_PD_O(BOOT_SPEED_STRAP_PD_O),
    .SERIAL_IN_PIN_I(so), .EXT_ROM_EN_O(EXT_ROM_EN_O), .BOOT_DONE_O(BOOT_DONE_O),
    .FETCH_WORD_O(FETCH_WORD_O));
  sfb_flash_model u_sfb_flash_model (.cs_n_i(SERIAL_CS_N_O), .sck_i(SERIAL_CLK_O), .io0_i(pin),
    .sig_ok_i(sig_q), .io1_o(so), .io0_o(fl_io0), .io0_oe_o(fl_oe));
  always #12.5 MCLK_I = ~MCLK_I;
  initial begin
    LINK_CLK_I = 1'b0;
    #1.3;
    forever #3 LINK_CLK_I = ~LINK_CLK_I;
  end
  always @(posedge SERIAL_CLK_O) rise_t = $realtime;
  always @(negedge SERIAL_CLK_O) hi_ns = int'($realtime - rise_t);
  task automatic give_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    // Let one edge pass so back-to-back calls never re-raise a strobe in the same step
    @(posedge MCLK_I);
    AVS_ADDRESS_I <= a;
    AVS_WRITEDATA_I <= d;
    AVS_READ_I <= !wr;
    AVS_WRITE_I <= wr;
    n = 0;
    do begin
      @(posedge MCLK_I);
      n++;
    end while (AVS_WAITREQUEST_O !== 1'b0 && n < 50);
    q = AVS_READDATA_O;
    AVS_READ_I <= 1'b0;
    AVS_WRITE_I <= 1'b0;
    if (n >= 50) begin
      failures++;
      give_verdict();
    end
  endtask : bus
  task automatic boot(input logic strap, input logic sig, input logic dual);
    logic [31:0] q;
    int n;
    strap_q <= strap;
    sig_q <= sig;
    RST_I <= 1'b1;
    // reset held at least 1 us
    repeat (RST_MIN_CYC) @(posedge MCLK_I);
    u_sfb_flash_model.addr_q.delete();
    chk("pd_oe_csn", 32'h5, {BOOT_SPEED_STRAP_PD_O, SERIAL_OUT_OE_O, SERIAL_CS_N_O});
    RST_I <= 1'b0;
    @(posedge MCLK_I);
    if (dual) bus(1'b1, CTL_ADDR, 32'h1, q);
    bus(1'b0, CTL_ADDR, 32'h0, q);
    chk("ctl_early", {30'h0, strap, dual}, q);
    chk("pd_off", 32'h0, BOOT_SPEED_STRAP_PD_O);
    n = 0;
    while (BOOT_DONE_O !== 1'b1 && n < 2000) begin
      @(posedge MCLK_I);
      n++;
    end
    chk("done_wait", 32'h1, n < 2000);
    if (n >= 2000) give_verdict();
    chk("ext_rom", sig, EXT_ROM_EN_O);
    chk("accesses", sig ? 32'h2 : 32'h1, u_sfb_flash_model.addr_q.size());
    chk("probe_addr", 32'h00fffa, u_sfb_flash_model.addr_q[0]);
    chk("clk_high_ns", strap ? 32'd12 : 32'd24, hi_ns);
    if (sig) begin
      chk("exec_addr", 32'h0, u_sfb_flash_model.addr_q[1]);
      bus(1'b0, FETCH_ADDR, 32'h0, q);
      chk("fetch_word", 32'ha5a4a7a6, q);
      chk("fetch_pin", 32'ha5a4a7a6, FETCH_WORD_O);
    end
    bus(1'b0, CTL_ADDR, 32'h0, q);
    chk("ctl_done", {28'h0, 1'b1, sig, strap, dual}, q);
    SUSPEND_I <= 1'b1;
    n = 0;
    while (SERIAL_OUT_OE_O !== !strap && n < 20) begin
      @(posedge MCLK_I);
      n++;
    end
    chk("susp_oe_out", {!strap, 1'b0}, {SERIAL_OUT_OE_O, SERIAL_OUT_O & SERIAL_OUT_OE_O});
    if (n >= 20) give_verdict();
    SUSPEND_I <= 1'b0;
  endtask : boot
  task automatic bus_misc;
    logic [31:0] q;
    bus(1'b0, 16'h1000, 32'h0, q);
    chk("unmapped", 32'h0, q);
    bus(1'b1, CTL_ADDR, 32'hffffffff, q);
    AVS_BYTEENABLE_I <= 4'he;
    bus(1'b1, CTL_ADDR, 32'h0, q);
    AVS_BYTEENABLE_I <= 4'hf;
    bus(1'b0, CTL_ADDR, 32'h0, q);
    chk("ctl_lane_gate", 32'hf, q);
    bus(1'b1, CTL_ADDR, 32'h0, q);
    bus(1'b0, CTL_ADDR, 32'h0, q);
    chk("ctl_ro_bits", 32'he, q);
  endtask : bus_misc
  initial begin
    MCLK_I = 1'b0;
    RST_I = 1'b1;
    SUSPEND_I = 1'b0;
    AVS_ADDRESS_I = 16'h0;
    AVS_READ_I = 1'b0;
    AVS_WRITE_I = 1'b0;
    AVS_WRITEDATA_I = 32'h0;
    AVS_BYTEENABLE_I = 4'hf;
    strap_q = 1'b1;
    sig_q = 1'b1;
    failures = 0;
    check_count = 0;
    hi_ns = 0;
    rise_t = 0.0;
    @(posedge MCLK_I);
    boot(1'b1, 1'b1, 1'b0);
    boot(1'b0, 1'b0, 1'b0);
    boot(1'b1, 1'b1, 1'b1);
    bus_misc();
    give_verdict();
  end
endmodule : sfb_top_tb
